// ### logic/bfs_sequencer.sv
// Functional notes
// - Turn low side off on zero-cross in normal auto-skip operation.
// - Enable high starts soft-start current into the ramp capacitor.
// - Power-good released after output within -8% and 1.5 ms after soft-start.
// - Overvoltage pulls power-good low at once until supply or enable cycle.
// - Undervoltage level pulls power-good low at once until reset.
// - Limit exceeded during low-side conduction blocks next high-side pulse.
// - Select pin picks 8, 12 or 16 A limit.
// - Negative limit magnitude equals positive limit.
// - Negative limit engaged only in out-of-bound or overvoltage operation.
// - Output 8% high enters forced-PWM out-of-bound discharge mode.
// - Overvoltage: low side on, minimum high-side pulse at negative limit.
// - Output reaching 0 V in overvoltage latches both switches off.
// - Overvoltage fault clears only by bias reset or enable cycle.
// - Undervoltage detection armed 1.4 ms after soft-start completes.
// - Undervoltage fault held until bias reset or enable cycle.
// - Bias supply below lockout shuts output off, resumes without latch.
// - Over-temperature shuts down unlatched, restarts with fresh soft-start.
`include "bfs_consts.svh"

module bfs_sequencer
	import bfs_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire logic       enable_i,
	input  wire logic       bias_por_ok_i,
	input  wire logic       supply_lockout_i,
	input  wire logic       over_temp_i,
	input  wire logic       soft_done_i,
	input  wire logic       pwm_demand_i,
	input  wire logic       zero_cross_i,
	input  wire logic       vout_pg_ok_i,
	input  wire logic       vout_oob_i,
	input  wire logic       vout_ov_i,
	input  wire logic       vout_uv_i,
	input  wire logic       vout_zero_i,
	input  wire logic [1:0] limit_select_pin_i,
	input  wire logic       current_limit_hit_i,
	input  wire logic       neg_limit_hit_i,
	output logic            soft_start_src_o,
	output logic            hs_on_o,
	output logic            ls_on_o,
	output logic            power_ok_output_oe_o,
	output logic            overvoltage_fault_o,
	output logic            undervoltage_fault_o,
	output logic            out_of_bound_discharge_o,
	output logic            neg_limit_en_o,
	output logic      [4:0] current_limit_o
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	bfs_state_t state_reg, state_next;
	bfs_ovph_t  ovph_reg;
	logic       ov_latch_reg, uv_latch_reg, pg_reg, ocl_block_reg;
	logic       ls_cond_reg;
	logic [7:0] min_on_reg;
	logic       pg_done, uv_armed, uv_filt_done;

	////////////////////////////////////////////////////////////////////////
	// Clearing terms
	// Enable low or bias below POR resets all latches and timers
	wire logic hard_clr_w  = !enable_i || !bias_por_ok_i;
	// Lockout and thermal are non-latching stops
	wire logic soft_stop_w = supply_lockout_i || over_temp_i;
	wire logic running_w   = (state_reg == ST_RUN);
	wire logic uv_now_w    = running_w && uv_armed && vout_uv_i;
	wire logic ov_now_w    = (state_reg == ST_RUN || state_reg == ST_SOFT) && vout_ov_i;

	////////////////////////////////////////////////////////////////////////
	// Timers referenced to the soft-start done flag
	bfs_delay #(.TARGET(`BFS_PG_DELAY_CYC)) u_pg_delay (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.clear_i (hard_clr_w),
		.run_i   (running_w && soft_done_i),
		.done_o  (pg_done)
	);
	bfs_delay #(.TARGET(`BFS_UV_ARM_CYC)) u_uv_arm (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.clear_i (hard_clr_w),
		.run_i   (running_w && soft_done_i),
		.done_o  (uv_armed)
	);
	// Filter restarts whenever the output climbs back above the threshold
	bfs_delay #(.TARGET(`BFS_UV_FILT_CYC)) u_uv_filt (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.clear_i (hard_clr_w),
		.run_i   (uv_now_w),
		.done_o  (uv_filt_done)
	);
	bfs_limit_sel u_limit (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.sel_i   (limit_select_pin_i),
		.limit_o (current_limit_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Main sequencer state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (enable_i && !soft_stop_w && !ov_latch_reg && !uv_latch_reg)
					state_next = ST_SOFT;
			end
			ST_SOFT: begin
				if (soft_stop_w)
					state_next = ST_OFF;
				else if (ov_now_w)
					state_next = ST_OVDIS;
				else if (soft_done_i)
					state_next = ST_RUN;
			end
			ST_RUN: begin
				if (soft_stop_w)
					state_next = ST_OFF;
				else if (ov_now_w)
					state_next = ST_OVDIS;
				else if (uv_filt_done)
					state_next = ST_LATCHED;
			end
			ST_OVDIS: begin
				// Lockout and thermal stop the discharge too; the OV latch keeps it off
				if (soft_stop_w)
					state_next = ST_OFF;
				else if (vout_zero_i)
					state_next = ST_LATCHED;
			end
			ST_LATCHED: state_next = ST_LATCHED;
			default: state_next = ST_OFF;
		endcase
		if (hard_clr_w)
			state_next = ST_OFF;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault latches; set loses to nothing but a hard clear
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ov_latch_reg <= 1'b0;
			uv_latch_reg <= 1'b0;
		end else if (hard_clr_w) begin
			ov_latch_reg <= 1'b0;
			uv_latch_reg <= 1'b0;
		end else begin
			if (ov_now_w)
				ov_latch_reg <= 1'b1;
			if (uv_filt_done && running_w)
				uv_latch_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-good: an output undervoltage or overvoltage is sticky until reset
	logic pg_limit_select_pin_reg;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pg_limit_select_pin_reg <= 1'b0;
			pg_reg      <= 1'b0;
		end else if (hard_clr_w) begin
			pg_limit_select_pin_reg <= 1'b0;
			pg_reg      <= 1'b0;
		end else if (vout_ov_i || (running_w && vout_uv_i)) begin
			pg_limit_select_pin_reg <= 1'b1;
			pg_reg      <= 1'b0;
		end else begin
			pg_reg <= !pg_limit_select_pin_reg && running_w && pg_done && vout_pg_ok_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Positive limit: sampled while low side conducts, blocks next high-side pulse
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ocl_block_reg <= 1'b0;
		end else if (ls_on_o) begin
			ocl_block_reg <= current_limit_hit_i;
		end else if (!current_limit_hit_i) begin
			ocl_block_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overvoltage discharge phase and minimum on-time
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovph_reg   <= OV_LS_ON;
			min_on_reg <= 8'h00;
		end else if (state_reg != ST_OVDIS) begin
			ovph_reg   <= OV_LS_ON;
			min_on_reg <= 8'h00;
		end else if (ovph_reg == OV_LS_ON && neg_limit_hit_i) begin
			ovph_reg   <= OV_HS_MIN;
			min_on_reg <= 8'(`BFS_MIN_ON_CYC - 1);
		end else if (ovph_reg == OV_HS_MIN) begin
			if (min_on_reg == 8'h00)
				ovph_reg <= OV_LS_ON;
			else
				min_on_reg <= min_on_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gate drive decode
	wire logic oob_w    = running_w && vout_oob_i;
	wire logic neg_en_w = oob_w || (state_reg == ST_OVDIS);
	wire logic active_w = (state_reg == ST_SOFT) || running_w;
	// High side on demand when not blocked by the limit, or for the overvoltage minimum pulse
	// Held demand keeps the high side on; the low side only follows once demand drops
	wire logic hs_w     = (active_w && pwm_demand_i && !ocl_block_reg && !(oob_w && neg_limit_hit_i)) ||
	                      (state_reg == ST_OVDIS && ovph_reg == OV_HS_MIN);
	// Auto-skip drops the low side at zero-cross; forced PWM does not
	wire logic ls_w     = (active_w && !pwm_demand_i && !hs_w && ls_cond_reg &&
	                       (oob_w ? !neg_limit_hit_i : !zero_cross_i)) ||
	                      (state_reg == ST_OVDIS && ovph_reg == OV_LS_ON && !neg_limit_hit_i);

	// Low side allowed after a high-side pulse until current returns to zero, or reaches the negative limit when out of bound
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ls_cond_reg <= 1'b0;
		end else if (hs_w) begin
			ls_cond_reg <= 1'b1;
		end else if (!ls_w) begin
			ls_cond_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hs_on_o                  <= 1'b0;
			ls_on_o                  <= 1'b0;
			soft_start_src_o         <= 1'b0;
			power_ok_output_oe_o     <= 1'b1;
			overvoltage_fault_o      <= 1'b0;
			undervoltage_fault_o     <= 1'b0;
			out_of_bound_discharge_o <= 1'b0;
			neg_limit_en_o           <= 1'b0;
		end else begin
			hs_on_o                  <= hs_w;
			ls_on_o                  <= ls_w;
			soft_start_src_o         <= (state_reg == ST_SOFT) || running_w;
			power_ok_output_oe_o     <= !pg_reg;
			overvoltage_fault_o      <= ov_latch_reg;
			undervoltage_fault_o     <= uv_latch_reg;
			out_of_bound_discharge_o <= oob_w;
			neg_limit_en_o           <= neg_en_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	latched_off_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		state_reg == ST_LATCHED |=> !hs_on_o && !ls_on_o) else $error("switch on while latched");
	ov_pg_low_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		vout_ov_i && !hard_clr_w |=> ##1 power_ok_output_oe_o) else $error("power ok not pulled on ov");
	uv_pg_low_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		running_w && vout_uv_i && !hard_clr_w |=> ##1 power_ok_output_oe_o) else $error("power ok not pulled on uv");
	pg_needs_delay_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!power_ok_output_oe_o |-> $past(pg_done, 2)) else $error("power ok before delay");
	ov_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ov_latch_reg && !hard_clr_w |=> ov_latch_reg) else $error("ov fault cleared early");
	uv_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		uv_latch_reg && !hard_clr_w |=> uv_latch_reg) else $error("uv fault cleared early");
	neg_only_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		neg_limit_en_o |-> $past(oob_w) || $past(state_reg) == ST_OVDIS) else $error("neg limit outside oob");
	stop_off_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		supply_lockout_i |=> ##1 !hs_on_o && !soft_start_src_o) else $error("running in lockout");
	ocl_block_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ocl_block_reg && state_reg != ST_OVDIS |=> !hs_on_o) else $error("high side despite limit");
	uv_arm_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!uv_armed |=> !uv_latch_reg || $past(uv_latch_reg)) else $error("uv set before arming");
	ov_min_on_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		state_reg == ST_OVDIS && $rose(ovph_reg == OV_HS_MIN) && !hard_clr_w && !vout_zero_i
		|-> (ovph_reg == OV_HS_MIN) [*8]) else $error("min on time too short");
	cov_pg_c:    cover property (@(posedge clock_i) $fell(power_ok_output_oe_o));
	cov_ovdis_c: cover property (@(posedge clock_i) state_reg == ST_OVDIS ##1 state_reg == ST_LATCHED);
	cov_uv_c:    cover property (@(posedge clock_i) $rose(uv_latch_reg));
	cov_oob_c:   cover property (@(posedge clock_i) $rose(out_of_bound_discharge_o));
endmodule

// ### logic/bfs_consts.svh
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH

// Clock period in ps (200 MHz)
`define BFS_CLK_PS          5000
// Power-good delay after soft-start end, in us
`define BFS_PG_DELAY_US     1500
// Undervoltage arming delay after soft-start end, in us
`define BFS_UV_ARM_US       1400
// Undervoltage filter time, in us
`define BFS_UV_FILT_US      1000
// Cycle counts derived from times and clock rate
`define BFS_PG_DELAY_CYC    ((`BFS_PG_DELAY_US * 1000000) / `BFS_CLK_PS)
`define BFS_UV_ARM_CYC      ((`BFS_UV_ARM_US * 1000000) / `BFS_CLK_PS)
`define BFS_UV_FILT_CYC     ((`BFS_UV_FILT_US * 1000000) / `BFS_CLK_PS)
// Minimum high-side on-time during overvoltage discharge, in cycles
`define BFS_MIN_ON_CYC      40
// Limit select encodings
`define BFS_SEL_GND         2'h0
`define BFS_SEL_5V          2'h1
`define BFS_SEL_FLOAT       2'h2
// Current limit levels in amperes
`define BFS_LIM_GND_A       5'h08
`define BFS_LIM_5V_A        5'h0C
`define BFS_LIM_FLOAT_A     5'h10
// Counter width
`define BFS_CNT_W           20

`endif

// ### logic/bfs_pkg.sv
package bfs_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_OVDIS,
		ST_LATCHED
	} bfs_state_t;
	typedef enum logic {
		OV_LS_ON,
		OV_HS_MIN
	} bfs_ovph_t;
endpackage

// ### logic/bfs_delay.sv
`include "bfs_consts.svh"

// Counts enabled cycles and flags once the target count has been reached
module bfs_delay
	import bfs_pkg::*;
#(
	parameter int unsigned TARGET = 16
) (
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	input  wire logic clear_i,
	input  wire logic run_i,
	output logic      done_o
);
	logic [`BFS_CNT_W-1:0] cnt_reg;
	localparam logic [`BFS_CNT_W-1:0] LAST = `BFS_CNT_W'(TARGET - 1);

	// Saturating counter; clear dominates run
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
			done_o  <= 1'b0;
		end else if (clear_i || !run_i) begin
			cnt_reg <= '0;
			done_o  <= 1'b0;
		end else if (cnt_reg != LAST) begin
			cnt_reg <= cnt_reg + `BFS_CNT_W'(1);
		end else begin
			done_o <= 1'b1;
		end
	end
endmodule

// ### logic/bfs_limit_sel.sv
`include "bfs_consts.svh"

// Maps the select-pin state to a current-limit level in amperes
module bfs_limit_sel
	import bfs_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire logic [1:0] sel_i,
	output logic      [4:0] limit_o
);
	// Unknown pin code falls back to the lowest, safest level
	wire logic [4:0] lim_w = (sel_i == `BFS_SEL_5V)    ? `BFS_LIM_5V_A :
	                         (sel_i == `BFS_SEL_FLOAT) ? `BFS_LIM_FLOAT_A : `BFS_LIM_GND_A;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			limit_o <= `BFS_LIM_GND_A;
		end else begin
			limit_o <= lim_w;
		end
	end
endmodule

// ### bench/bfs_power_stage.sv
// Behavioural power stage: inductor current plus the three comparators
module bfs_power_stage (
	input  wire logic              clock_i,
	input  wire logic              rst_b_i,
	input  wire logic              hs_on_i,
	input  wire logic              ls_on_i,
	input  wire logic        [4:0] limit_a_i,
	input  wire logic              surge_i,
	output logic                   zero_cross_o,
	output logic                   current_limit_hit_o,
	output logic                   neg_limit_hit_o,
	output logic signed      [7:0] cur_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic signed [7:0] lim;

	assign lim = $signed({3'h0, limit_a_i});

	////////////////////////////////////////////////////////////////////////////
	// One ampere per clock; with both switches off the current bleeds to zero
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_o <= 8'sh00;
		end else if (surge_i) begin
			cur_o <= lim + 8'sh04; // Stuck overload, only when a test asks
		end else if (hs_on_i) begin
			cur_o <= cur_o + 8'sh01;
		end else if (ls_on_i) begin
			cur_o <= cur_o - 8'sh01;
		end else if (cur_o > 8'sh00) begin
			cur_o <= cur_o - 8'sh01;
		end else if (cur_o < 8'sh00) begin
			cur_o <= cur_o + 8'sh01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparators; the negative limit uses the same magnitude as the positive
	assign current_limit_hit_o = (cur_o >= lim);
	assign neg_limit_hit_o     = (cur_o <= -lim);
	assign zero_cross_o        = ls_on_i && (cur_o <= 8'sh00);
endmodule

// ### bench/testbench.sv
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic              clock_i, rst_b_i, enable_i, bias_por_ok_i, supply_lockout_i, over_temp_i;
	logic              soft_done_i, pwm_demand_i, vout_pg_ok_i, vout_oob_i, vout_ov_i, vout_uv_i, vout_zero_i;
	logic        [1:0] limit_select_pin_i;
	logic              zero_cross, limit_hit, neg_hit, surge;
	logic              soft_start_src_o, hs_on_o, ls_on_o, power_ok_output_oe_o, overvoltage_fault_o;
	logic              undervoltage_fault_o, out_of_bound_discharge_o, neg_limit_en_o;
	logic        [4:0] current_limit_o;
	logic signed [7:0] cur, min_cur;
	logic              seen_ls;
	int                hs_cnt, num_errors, compares, cycles;

	bfs_sequencer dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .enable_i(enable_i), .bias_por_ok_i(bias_por_ok_i),
		.supply_lockout_i(supply_lockout_i), .over_temp_i(over_temp_i), .soft_done_i(soft_done_i),
		.pwm_demand_i(pwm_demand_i), .zero_cross_i(zero_cross), .vout_pg_ok_i(vout_pg_ok_i),
		.vout_oob_i(vout_oob_i), .vout_ov_i(vout_ov_i), .vout_uv_i(vout_uv_i), .vout_zero_i(vout_zero_i),
		.limit_select_pin_i(limit_select_pin_i), .current_limit_hit_i(limit_hit), .neg_limit_hit_i(neg_hit),
		.soft_start_src_o(soft_start_src_o), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o),
		.power_ok_output_oe_o(power_ok_output_oe_o), .overvoltage_fault_o(overvoltage_fault_o),
		.undervoltage_fault_o(undervoltage_fault_o), .out_of_bound_discharge_o(out_of_bound_discharge_o),
		.neg_limit_en_o(neg_limit_en_o), .current_limit_o(current_limit_o));

	bfs_power_stage stage (.clock_i(clock_i), .rst_b_i(rst_b_i), .hs_on_i(hs_on_o), .ls_on_i(ls_on_o),
		.limit_a_i(current_limit_o), .surge_i(surge), .zero_cross_o(zero_cross),
		.current_limit_hit_o(limit_hit), .neg_limit_hit_o(neg_hit), .cur_o(cur));

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the ceiling is well above the planned run
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task automatic clr();
		min_cur = 8'sh00;
		seen_ls = 1'b0;
		hs_cnt = 0;
	endtask

	// Step n cycles, noting lowest current and switch activity
	task automatic track(input int n);
		repeat (n) begin
			@(negedge clock_i);
			if (cur < min_cur) min_cur = cur;
			if (ls_on_o === 1'b1) seen_ls = 1'b1;
			if (hs_on_o === 1'b1) hs_cnt++;
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic start_up();
		enable_i = 1'b1;
		cyc(1);
		`CHECK(soft_start_src_o, 1'b0)
		cyc(1);
		`CHECK(soft_start_src_o, 1'b1)
		vout_pg_ok_i = 1'b1;
		soft_done_i = 1'b1;
		cyc(1000);
		`CHECK(power_ok_output_oe_o, 1'b1)
	endtask

	task automatic limit_sel();
		for (int i = 0; i < 4; i++) begin
			limit_select_pin_i = 2'(i);
			cyc(2);
			`CHECK(current_limit_o, (i == 1) ? 5'h0C : (i == 2) ? 5'h10 : 5'h08)
		end
	endtask

	// Back-to-back light-load pulses must never drive the current below -2 A
	task automatic skip_check();
		for (int k = 0; k < 3; k++) begin
			clr();
			pwm_demand_i = 1'b1;
			cyc(4);
			pwm_demand_i = 1'b0;
			track(30);
			`CHECK(seen_ls, 1'b1)
			`CHECK(ls_on_o, 1'b0)
			`CHECK(min_cur >= -8'sh02, 1'b1)
			`CHECK(neg_limit_en_o, 1'b0)
		end
	endtask

	task automatic ocl_check();
		pwm_demand_i = 1'b1;
		cyc(2);
		pwm_demand_i = 1'b0;
		surge = 1'b1;
		cyc(3);
		pwm_demand_i = 1'b1;
		clr();
		track(10);
		`CHECK(hs_cnt, 0)
		surge = 1'b0;
		clr();
		track(30);
		`CHECK(hs_cnt > 0, 1'b1)
		pwm_demand_i = 1'b0;
		cyc(60);
	endtask

	// Undervoltage ahead of the arming delay must not latch
	task automatic uv_early();
		vout_uv_i = 1'b1;
		cyc(2000);
		`CHECK(undervoltage_fault_o, 1'b0)
		`CHECK(power_ok_output_oe_o, 1'b1)
		vout_uv_i = 1'b0;
		cyc(2);
	endtask

	task automatic oob_check();
		vout_oob_i = 1'b1;
		cyc(3);
		`CHECK(out_of_bound_discharge_o, 1'b1)
		`CHECK(neg_limit_en_o, 1'b1)
		clr();
		pwm_demand_i = 1'b1;
		cyc(3);
		pwm_demand_i = 1'b0;
		track(30);
		`CHECK(min_cur <= -8'sh03, 1'b1)
		`CHECK(min_cur >= -8'sh0A, 1'b1)
		vout_oob_i = 1'b0;
		cyc(3);
		`CHECK(out_of_bound_discharge_o, 1'b0)
		`CHECK(neg_limit_en_o, 1'b0)
		cyc(40);
	endtask

	// Supply lockout or over-temperature: both off, no latch, fresh ramp after
	task automatic stop_check(input bit lockout);
		pwm_demand_i = 1'b1;
		if (lockout) supply_lockout_i = 1'b1;
		else over_temp_i = 1'b1;
		cyc(3);
		soft_done_i = 1'b0;
		clr();
		track(10);
		`CHECK(hs_cnt, 0)
		`CHECK(seen_ls, 1'b0)
		`CHECK(soft_start_src_o, 1'b0)
		supply_lockout_i = 1'b0;
		over_temp_i = 1'b0;
		cyc(4);
		`CHECK(soft_start_src_o, 1'b1)
		`CHECK(overvoltage_fault_o | undervoltage_fault_o, 1'b0)
		soft_done_i = 1'b1;
		pwm_demand_i = 1'b0;
		cyc(40);
	endtask

	task automatic ov_check();
		int n;
		vout_ov_i = 1'b1;
		cyc(3);
		`CHECK(power_ok_output_oe_o, 1'b1)
		`CHECK(overvoltage_fault_o, 1'b1)
		`CHECK({hs_on_o, ls_on_o}, 2'h1)
		`CHECK(neg_limit_en_o, 1'b1)
		n = 0;
		while (hs_on_o !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		clr();
		hs_cnt = 1;
		while (hs_on_o === 1'b1 && hs_cnt < 100) track(1);
		`CHECK(hs_cnt, 40)
		cyc(1);
		`CHECK(ls_on_o, 1'b1)
		vout_zero_i = 1'b1;
		cyc(3);
		vout_ov_i = 1'b0;
		vout_zero_i = 1'b0;
		clr();
		track(20);
		`CHECK({hs_cnt != 0, seen_ls}, 2'h0)
		`CHECK(overvoltage_fault_o, 1'b1)
		bias_por_ok_i = 1'b0;
		soft_done_i = 1'b0;
		cyc(2);
		`CHECK(overvoltage_fault_o, 1'b0)
		bias_por_ok_i = 1'b1;
		cyc(4);
		`CHECK(soft_start_src_o, 1'b1)
		enable_i = 1'b0;
		cyc(2);
		`CHECK(soft_start_src_o, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; supplies are up before enable is raised
	initial begin
		{rst_b_i, enable_i, supply_lockout_i, over_temp_i, soft_done_i, pwm_demand_i} = 6'h00;
		{vout_pg_ok_i, vout_oob_i, vout_ov_i, vout_uv_i, vout_zero_i, surge} = 6'h00;
		bias_por_ok_i = 1'b1;
		limit_select_pin_i = 2'h0;
		num_errors = 0;
		compares = 0;
		cycles = 0;
		cyc(6);
		`CHECK({power_ok_output_oe_o, current_limit_o, hs_on_o, ls_on_o}, 8'hA0)
		rst_b_i = 1'b1;
		cyc(2);
		start_up();
		limit_sel();
		skip_check();
		ocl_check();
		uv_early();
		oob_check();
		stop_check(1'b1);
		stop_check(1'b0);
		ov_check();
		tally_and_finish();
	end
endmodule
